// >>> tilt_angle_postproc_and_error_flags.sv
// angle post-processing, temperature supervision and error register of the inclinometer
`timescale 1ns/1ps
`default_nettype none
`include "tilt_defines.svh"
module tilt_angle_postproc_and_error_flags #(
    parameter int unsigned TEMP_CHECK_CYCLES = `TEMP_CHECK_CYCLES  // one-second check period
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // dictionary access from the protocol engine
    input  wire tilt_pkg::dict_req_s dict_req,
    output logic [15:0]            dict_rdata,
    output logic                   dict_ack,
    output logic                   dict_err,
    // acquisition inputs, absolute angles in thousandths of a degree
    input  wire logic              sample_valid,
    input  wire logic signed [19:0] abs_angle1_mdeg,
    input  wire logic signed [19:0] abs_angle2_mdeg,
    input  wire logic signed [7:0] temp_reading,
    // mode straps and fault sources
    input  wire logic              single_axis,
    input  wire logic              comm_error,
    input  wire logic              axis_range_error,
    input  wire logic              crc_fail,
    input  wire logic              selftest_fail,
    // outputs toward process data and emergency framing
    output logic signed [15:0]     angle1_out,
    output logic signed [15:0]     angle2_out,
    output logic signed [7:0]      temp_out,
    output tilt_pkg::emcy_s        emcy
);
    import tilt_pkg::*;

    // configuration registers
    logic [7:0]         temp_en_r;        // supervision enable sub-entry
    logic signed [7:0]  temp_lo_r;        // lower limit
    logic signed [7:0]  temp_hi_r;        // upper limit
    logic [15:0]        res_r;            // step size in thousandths
    logic               fmt_signed_r;     // single-axis format, 1 = -180..180
    logic [7:0]         inv_r [2];        // per-axis inversion entry
    logic signed [15:0] preset_r [2];     // per-axis preset
    logic signed [15:0] offset_r [2];     // per-axis offset in resolution steps
    // state
    logic signed [7:0]  temp_r;           // latest temperature
    logic               temp_err_r;       // temperature out of window
    logic [7:0]         err_r;            // error byte
    logic [31:0]        sec_cnt_r;        // check period counter
    temp_state_e        ts_r;             // check sequencer
    logic signed [15:0] meas_r [2];       // reported angles

    // write decode helpers
    logic        wr_ok;
    logic        axis2_blocked;
    logic signed [15:0] abs_steps [2];    // absolute angles in resolution steps
    logic signed [19:0] abs_in [2];
    logic        range_err;

    assign abs_in[0] = abs_angle1_mdeg;
    assign abs_in[1] = abs_angle2_mdeg;
    // second-axis entries vanish in single-axis mode
    assign axis2_blocked = single_axis &&
                           (dict_req.index[15:4] == 12'(`IDX_AXIS2_MEASURED >> 4));

    // absolute angle scaled to the selected step; the division is combinational and follows every input change, not only samples
    generate
        for (genvar a = 0; a < 2; a++) begin : g_scale
            logic signed [19:0] q;
            always_comb begin
                q = abs_in[a];
                if (res_r == `RES_WHOLE) begin
                    q = abs_in[a] / 20'sd1000;
                end else if (res_r == `RES_TENTH) begin
                    q = abs_in[a] / 20'sd100;
                end else if (res_r == `RES_HUNDREDTH) begin
                    q = abs_in[a] / 20'sd10;
                end
                abs_steps[a] = q[15:0];
            end
        end
    endgenerate

    // angle beyond the absolute span for the resolution in use; coarser steps go unchecked in single-axis mode
    always_comb begin
        range_err = 1'b0;
        for (int a = 0; a < 2; a++) begin
            if (res_r == `RES_THOUSANDTH) begin
                if (abs_in[a] > 20'sd30000 || abs_in[a] < -20'sd30000) range_err = 1'b1;
            end else if (!single_axis) begin
                if (abs_in[a] > 20'sd60000 || abs_in[a] < -20'sd60000) range_err = 1'b1;
            end
        end
    end

    // a write is legal when it targets a writable, enabled entry
    always_comb begin
        wr_ok = 1'b0;
        if (axis2_blocked) begin
            wr_ok = 1'b0;
        end else if (dict_req.index == `IDX_TEMP_SUPERVISION) begin
            wr_ok = (dict_req.sub == `SUB_TEMP_ENABLE) ? (dict_req.wdata[7:0] <= 8'h01) :
                    (dict_req.sub == `SUB_TEMP_LOWER || dict_req.sub == `SUB_TEMP_UPPER) ?
                    ($signed(dict_req.wdata[7:0]) >= `TEMP_SETTING_MIN &&
                     $signed(dict_req.wdata[7:0]) <= `TEMP_SETTING_MAX) : 1'b0;
        end else if (dict_req.index == `IDX_ANGLE_RESOLUTION) begin
            wr_ok = dict_req.wdata == `RES_WHOLE || dict_req.wdata == `RES_TENTH ||
                    dict_req.wdata == `RES_HUNDREDTH || dict_req.wdata == `RES_THOUSANDTH;
        end else if (dict_req.index == `IDX_SINGLE_FORMAT) begin
            wr_ok = 1'b1;
        end else if (dict_req.index inside {`IDX_AXIS1_INVERT, `IDX_AXIS1_PRESET,
                     `IDX_AXIS1_OFFSET, `IDX_AXIS2_INVERT, `IDX_AXIS2_PRESET,
                     `IDX_AXIS2_OFFSET}) begin
            wr_ok = 1'b1;
        end
    end

    // temperature supervision configuration
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            temp_en_r <= `TEMP_ENABLE_OFF;
            temp_lo_r <= `TEMP_LOWER_RESET;
            temp_hi_r <= `TEMP_UPPER_RESET;
        end else if (dict_req.wr && wr_ok && dict_req.index == `IDX_TEMP_SUPERVISION) begin
            if (dict_req.sub == `SUB_TEMP_ENABLE) temp_en_r <= dict_req.wdata[7:0];
            if (dict_req.sub == `SUB_TEMP_LOWER) temp_lo_r <= dict_req.wdata[7:0];
            if (dict_req.sub == `SUB_TEMP_UPPER) temp_hi_r <= dict_req.wdata[7:0];
        end
    end

    // resolution and single-axis format
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            res_r        <= `RES_THOUSANDTH;
            fmt_signed_r <= 1'b0;
        end else if (dict_req.wr && wr_ok) begin
            if (dict_req.index == `IDX_ANGLE_RESOLUTION) res_r <= dict_req.wdata;
            if (dict_req.index == `IDX_SINGLE_FORMAT) fmt_signed_r <= dict_req.wdata[0];
        end
    end

    // per-axis inversion, preset and offset; preset overwrites offset from the current angle
    generate
        for (genvar a = 0; a < 2; a++) begin : g_axis
            localparam logic [15:0] BASE = (a == 0) ? `IDX_AXIS1_MEASURED : `IDX_AXIS2_MEASURED;
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    inv_r[a]    <= 8'h00;
                    preset_r[a] <= 16'sh0000;
                    offset_r[a] <= 16'sh0000;
                end else if (dict_req.wr && wr_ok) begin
                    if (dict_req.index == BASE + 16'h0001) inv_r[a] <= dict_req.wdata[7:0];
                    if (dict_req.index == BASE + 16'h0003) offset_r[a] <= dict_req.wdata;
                    if (dict_req.index == BASE + 16'h0002) begin
                        preset_r[a] <= dict_req.wdata;
                        // zero preset yields the negated inclination here
                        offset_r[a] <= 16'(dict_req.wdata - abs_steps[a]);
                    end
                end
            end
        end
    endgenerate

    // reported angles; full circle in steps depends on the resolution
    always_ff @(posedge mclk) begin
        logic signed [19:0] v;
        logic signed [19:0] circle;
        if (!rst_n) begin
            meas_r[0] <= 16'sh0000;
            meas_r[1] <= 16'sh0000;
        end else if (sample_valid) begin
            for (int a = 0; a < 2; a++) begin
                v = 20'(abs_steps[a] + offset_r[a]);
                circle = 20'(`FULL_CIRCLE_MDEG / 1000) * 20'(1000 / res_r);
                if (inv_r[a] == `INVERT_ON) begin
                    if (single_axis && a == 0 && !fmt_signed_r && v != 20'sd0) begin
                        v = circle - v;
                    end else begin
                        v = -v;
                    end
                end
                if (a == 1 && single_axis) v = 20'sd0;
                meas_r[a] <= v[15:0];
            end
        end
    end

    // latest temperature
    always_ff @(posedge mclk) begin
        if (!rst_n) temp_r <= 8'sh00;
        else temp_r <= temp_reading;
    end

    // once-per-second window check sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sec_cnt_r  <= 32'h0;
            ts_r       <= TS_IDLE;
            temp_err_r <= 1'b0;
        end else begin
            case (ts_r)
                TS_IDLE: begin
                    if (sec_cnt_r >= TEMP_CHECK_CYCLES - 1) begin
                        sec_cnt_r <= 32'h0;
                        ts_r      <= TS_CHECK;
                    end else begin
                        sec_cnt_r <= sec_cnt_r + 32'h1;
                    end
                end
                TS_CHECK: begin
                    sec_cnt_r <= sec_cnt_r + 32'h1;
                    ts_r      <= TS_IDLE;
                    if (temp_en_r == `TEMP_ENABLE_ON) begin
                        temp_err_r <= (temp_r < temp_lo_r) || (temp_r > temp_hi_r);
                    end else begin
                        temp_err_r <= 1'b0;
                    end
                end
                default: ts_r <= TS_IDLE;
            endcase
        end
    end

    // error byte mirrors the currently active sources
    logic [7:0] err_nxt;
    always_comb begin
        err_nxt = 8'h00;
        err_nxt[`ERR_BIT_TEMP]    = temp_err_r;
        err_nxt[`ERR_BIT_COMM]    = comm_error;
        err_nxt[`ERR_BIT_PROFILE] = axis_range_error || range_err;
        err_nxt[`ERR_BIT_HW]      = crc_fail || selftest_fail;
        err_nxt[`ERR_BIT_ANY]     = |err_nxt;
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) err_r <= 8'h00;
        else err_r <= err_nxt;
    end

    // emergency on any newly set error bit, error reset when everything clears
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            emcy <= '0;
        end else begin
            emcy.send      <= (err_nxt[7:1] & ~err_r[7:1]) != 7'h00 ||
                              (err_r[0] && !err_nxt[0]);
            emcy.reset_msg <= err_r[0] && !err_nxt[0];
            emcy.err_reg   <= err_nxt;
        end
    end

    // dictionary read path and write answer; blocked or unknown entries are refused
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dict_rdata <= 16'h0000;
            dict_ack   <= 1'b0;
            dict_err   <= 1'b0;
        end else begin
            dict_ack <= dict_req.rd || dict_req.wr;
            dict_err <= dict_req.wr && !wr_ok;
            if (dict_req.rd) begin
                dict_err <= axis2_blocked;
                if (axis2_blocked) dict_rdata <= 16'h0000;
                else if (dict_req.index == `IDX_ERROR_SUMMARY) dict_rdata <= {8'h00, err_r};
                else if (dict_req.index == `IDX_INT_TEMP) dict_rdata <= 16'(temp_r);
                else if (dict_req.index == `IDX_TEMP_SUPERVISION && dict_req.sub == `SUB_TEMP_ENABLE)
                    dict_rdata <= {8'h00, temp_en_r};
                else if (dict_req.index == `IDX_TEMP_SUPERVISION && dict_req.sub == `SUB_TEMP_LOWER)
                    dict_rdata <= {{8{temp_lo_r[7]}}, temp_lo_r};
                else if (dict_req.index == `IDX_TEMP_SUPERVISION && dict_req.sub == `SUB_TEMP_UPPER)
                    dict_rdata <= {{8{temp_hi_r[7]}}, temp_hi_r};
                else if (dict_req.index == `IDX_ANGLE_RESOLUTION) dict_rdata <= res_r;
                else if (dict_req.index == `IDX_SINGLE_FORMAT) dict_rdata <= {15'h0, fmt_signed_r};
                else if (dict_req.index == `IDX_AXIS1_MEASURED) dict_rdata <= meas_r[0];
                else if (dict_req.index == `IDX_AXIS1_INVERT) dict_rdata <= {8'h00, inv_r[0]};
                else if (dict_req.index == `IDX_AXIS1_PRESET) dict_rdata <= preset_r[0];
                else if (dict_req.index == `IDX_AXIS1_OFFSET) dict_rdata <= offset_r[0];
                else if (dict_req.index == `IDX_AXIS2_MEASURED) dict_rdata <= meas_r[1];
                else if (dict_req.index == `IDX_AXIS2_INVERT) dict_rdata <= {8'h00, inv_r[1]};
                else if (dict_req.index == `IDX_AXIS2_PRESET) dict_rdata <= preset_r[1];
                else if (dict_req.index == `IDX_AXIS2_OFFSET) dict_rdata <= offset_r[1];
                else begin
                    dict_rdata <= 16'h0000;
                    dict_err   <= 1'b1;
                end
            end
        end
    end

    // process-data outputs come straight from registers
    assign angle1_out = meas_r[0];
    assign angle2_out = meas_r[1];
    assign temp_out   = temp_r;

endmodule // tilt_angle_postproc_and_error_flags
`default_nettype wire

// >>> tilt_defines.svh
// offsets, field positions, reset values and timing counts for the tilt post-processor
`ifndef TILT_DEFINES_SVH
`define TILT_DEFINES_SVH
`define IDX_ERROR_SUMMARY     16'h1001
`define IDX_INT_TEMP          16'h5000
`define IDX_TEMP_SUPERVISION  16'h5001
`define IDX_ANGLE_RESOLUTION  16'h6000
`define IDX_SINGLE_FORMAT     16'h3002
`define IDX_AXIS1_MEASURED    16'h6010
`define IDX_AXIS1_INVERT      16'h6011
`define IDX_AXIS1_PRESET      16'h6012
`define IDX_AXIS1_OFFSET      16'h6013
`define IDX_AXIS2_MEASURED    16'h6020
`define IDX_AXIS2_INVERT      16'h6021
`define IDX_AXIS2_PRESET      16'h6022
`define IDX_AXIS2_OFFSET      16'h6023
`define SUB_TEMP_ENABLE       8'h01
`define SUB_TEMP_LOWER        8'h02
`define SUB_TEMP_UPPER        8'h03
`define TEMP_ENABLE_ON        8'h01
`define TEMP_ENABLE_OFF       8'h00
`define TEMP_SETTING_MIN      (-8'sd55)
`define TEMP_SETTING_MAX      (8'sd120)
`define TEMP_LOWER_RESET      8'hE2
`define TEMP_UPPER_RESET      8'h4B
`define RES_WHOLE             16'h03E8
`define RES_TENTH             16'h0064
`define RES_HUNDREDTH         16'h000A
`define RES_THOUSANDTH        16'h0001
`define INVERT_ON             8'h01
`define ERR_BIT_ANY           0
`define ERR_BIT_TEMP          3
`define ERR_BIT_COMM          4
`define ERR_BIT_PROFILE       5
`define ERR_BIT_HW            7
`define SPAN_THOUSANDTH_MDEG  30000
`define SPAN_OTHER_MDEG       60000
`define FULL_CIRCLE_MDEG      360000
`define TEMP_CHECK_PERIOD_MS  1000
`define CLK_FREQ_KHZ          100000
`define TEMP_CHECK_CYCLES     (`TEMP_CHECK_PERIOD_MS * `CLK_FREQ_KHZ)
`endif

// >>> tilt_pkg.sv
// types shared by the tilt post-processor
package tilt_pkg;
    // one dictionary access from the protocol engine
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [15:0] wdata;
    } dict_req_s;
    // emergency event toward the protocol engine
    typedef struct packed {
        logic       send;
        logic       reset_msg;
        logic [7:0] err_reg;
    } emcy_s;
    // temperature check sequencer
    typedef enum logic [1:0] {
        TS_IDLE  = 2'b00,
        TS_CHECK = 2'b01
    } temp_state_e;
endpackage

// >>> tilt_dict_master.sv
// dictionary-access master model standing in for the remote network master
`timescale 1ns/1ps
`default_nettype none
module tilt_dict_master (
    // clock
    input  wire logic          mclk,
    // request toward the block
    output tilt_pkg::dict_req_s dict_req,
    // answer from the block
    input  wire logic [15:0]   dict_rdata,
    input  wire logic          dict_ack,
    input  wire logic          dict_err
);
    import tilt_pkg::*;
    initial dict_req = '0;  // idle from time zero
    // one access: a one-cycle pulse, answer taken while the ack stands
    task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
                        input logic [15:0] d, output logic e, output logic [15:0] r);
        int n = 0;
        @(negedge mclk);
        dict_req = '{wr: w, rd: !w, index: i, sub: s, wdata: d};
        @(negedge mclk);
        dict_req = '0;
        // bounded wait, the ack is expected on the first look
        while (dict_ack !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        e = (n < 4) ? dict_err : 1'bx;  // unknown marks a missing answer
        r = dict_rdata;
    endtask
endmodule // tilt_dict_master
`default_nettype wire

// >>> tilt_angle_postproc_and_error_flags_assertions.sv
// concurrent checks on the ports of the tilt post-processor
`timescale 1ns/1ps
`default_nettype none
`include "tilt_defines.svh"
module tilt_checker #(
    parameter int unsigned TEMP_CHECK_CYCLES = 20  // handed on from the block
) (
    // clock, reset, dictionary access
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire tilt_pkg::dict_req_s dict_req,
    input wire logic [15:0]         dict_rdata,
    input wire logic                dict_ack,
    input wire logic                dict_err,
    // acquisition and fault sources
    input wire logic                sample_valid,
    input wire logic signed [19:0]  abs_angle1_mdeg,
    input wire logic signed [19:0]  abs_angle2_mdeg,
    input wire logic signed [7:0]   temp_reading,
    input wire logic                single_axis,
    input wire logic                comm_error,
    input wire logic                axis_range_error,
    input wire logic                crc_fail,
    input wire logic                selftest_fail,
    // results
    input wire logic signed [15:0]  angle1_out,
    input wire logic signed [15:0]  angle2_out,
    input wire logic signed [7:0]   temp_out,
    input wire tilt_pkg::emcy_s     emcy
);
    import tilt_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // a rising fault reaches the emergency path within a few edges
    sequence flag_sent(int b);
        ##[1:4] (emcy.send && emcy.err_reg[b]);
    endsequence
    property src_reported(logic src, int b);
        $rose(src) |-> flag_sent(b);
    endproperty
    ack_answer_a: assert property (
        (dict_req.wr || dict_req.rd) |=> dict_ack) else $error("access not answered");
    ro_refused_a: assert property (
        dict_req.wr && dict_req.index inside {`IDX_ERROR_SUMMARY, `IDX_INT_TEMP,
        `IDX_AXIS1_MEASURED, `IDX_AXIS2_MEASURED} |=> dict_err) else $error("ro write taken");
    res_refused_a: assert property (
        dict_req.wr && dict_req.index == `IDX_ANGLE_RESOLUTION && !(dict_req.wdata inside
        {`RES_WHOLE, `RES_TENTH, `RES_HUNDREDTH, `RES_THOUSANDTH}) |=> dict_err)
        else $error("bad resolution taken");
    limit_refused_a: assert property (
        dict_req.wr && dict_req.index == `IDX_TEMP_SUPERVISION && dict_req.sub inside {8'h02, 8'h03}
        && ($signed(dict_req.wdata[7:0]) < -55 || $signed(dict_req.wdata[7:0]) > 120)
        |=> dict_err) else $error("bad limit taken");
    second_axis_off_a: assert property (
        single_axis && dict_req.wr && dict_req.index[15:4] == 12'h602 |=> dict_err)
        else $error("second axis written in single mode");
    angle_hold_a: assert property (
        !$past(sample_valid) |-> $stable(angle1_out)) else $error("angle moved without sample");
    sum_bit_a: assert property (
        emcy.send |-> emcy.err_reg[0] == |emcy.err_reg[7:1]) else $error("summary bit wrong");
    reset_msg_a: assert property (
        emcy.reset_msg |-> emcy.send && emcy.err_reg == 8'h00) else $error("bad recovery message");
    crc_flag_a: assert property (
        src_reported(crc_fail, 7)) else $error("crc fault not reported");
    comm_flag_a: assert property (
        src_reported(comm_error, 4)) else $error("comm fault not reported");
endmodule // tilt_checker
bind tilt_angle_postproc_and_error_flags tilt_checker #(.TEMP_CHECK_CYCLES(TEMP_CHECK_CYCLES)) chk (
    .mclk(mclk), .rst_n(rst_n), .dict_req(dict_req), .dict_rdata(dict_rdata),
    .dict_ack(dict_ack), .dict_err(dict_err), .sample_valid(sample_valid),
    .abs_angle1_mdeg(abs_angle1_mdeg), .abs_angle2_mdeg(abs_angle2_mdeg),
    .temp_reading(temp_reading), .single_axis(single_axis), .comm_error(comm_error),
    .axis_range_error(axis_range_error), .crc_fail(crc_fail), .selftest_fail(selftest_fail),
    .angle1_out(angle1_out), .angle2_out(angle2_out), .temp_out(temp_out), .emcy(emcy));
`default_nettype wire

// >>> tilt_angle_postproc_and_error_flags_bench.sv
// self-checking bench for the tilt post-processor
`timescale 1ns/1ps
`default_nettype none
`include "tilt_defines.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tilt_angle_postproc_and_error_flags_bench;
    import tilt_pkg::*;
    localparam int unsigned CYC = 20;        // shortened one-second check period
    logic               mclk = 1'b0;         // 100 MHz
    logic               rst_n = 1'b0;        // held low for 16 cycles
    dict_req_s          dict_req;            // from the master model
    logic [15:0]        dict_rdata;
    logic               dict_ack;
    logic               dict_err;
    logic               sample_valid = 1'b0;
    logic signed [19:0] abs1 = '0;
    logic signed [19:0] abs2 = '0;
    logic signed [7:0]  temp_reading = 8'sd20;
    logic               single_axis = 1'b0;
    logic [3:0]         faults = 4'h0;       // comm, range, crc, selftest
    logic signed [15:0] angle1_out;
    logic signed [15:0] angle2_out;
    logic signed [7:0]  temp_out;
    emcy_s              emcy;
    int                 bad_count = 0;
    int                 check_count = 0;
    logic               e;                   // refusal of the last access
    logic [15:0]        r;                   // data of the last read
    always #5 mclk = ~mclk;
    tilt_angle_postproc_and_error_flags #(.TEMP_CHECK_CYCLES(CYC)) DUT (
        .mclk(mclk), .rst_n(rst_n), .dict_req(dict_req), .dict_rdata(dict_rdata),
        .dict_ack(dict_ack), .dict_err(dict_err), .sample_valid(sample_valid),
        .abs_angle1_mdeg(abs1), .abs_angle2_mdeg(abs2), .temp_reading(temp_reading),
        .single_axis(single_axis), .comm_error(faults[0]), .axis_range_error(faults[1]),
        .crc_fail(faults[2]), .selftest_fail(faults[3]), .angle1_out(angle1_out),
        .angle2_out(angle2_out), .temp_out(temp_out), .emcy(emcy));
    tilt_dict_master M (.mclk(mclk), .dict_req(dict_req), .dict_rdata(dict_rdata),
        .dict_ack(dict_ack), .dict_err(dict_err));
    // verdict and end of run, also reached when a wait runs out
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one access; a missing answer ends the run
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [15:0] d);
        M.xfer(w, i, s, d, e, r);
        if (e === 1'bx) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic rchk(input logic [15:0] i, input logic [7:0] s, input logic [15:0] ex);
        acc(1'b0, i, s, 16'h0000);
        `CHK($sformatf("read %h.%h", i, s), ex, r)
    endtask
    task automatic wchk(input logic [15:0] i, input logic [7:0] s, input logic [15:0] d,
                        input logic ex);
        acc(1'b1, i, s, d);
        `CHK($sformatf("refuse %h.%h", i, s), ex, e)
    endtask
    // present one pair of absolute angles, results land a cycle later
    task automatic sample(input int a1, input int a2);
        @(negedge mclk);
        abs1 = 20'(a1);
        abs2 = 20'(a2);
        sample_valid = 1'b1;
        @(negedge mclk);
        sample_valid = 1'b0;
    endtask
    // bounded watch for one emergency event
    task automatic wait_send(output logic seen, output logic [7:0] er, output logic rm);
        seen = 1'b0;
        for (int n = 0; n < 3 * CYC && !seen; n++) begin
            @(negedge mclk);
            seen = emcy.send;
            er = emcy.err_reg;
            rm = emcy.reset_msg;
        end
    endtask
    task automatic t_reset();
        rchk(`IDX_ANGLE_RESOLUTION, 8'h00, `RES_THOUSANDTH);
        rchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_LOWER, 16'hFFE2);
        rchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_UPPER, 16'h004B);
        rchk(`IDX_ERROR_SUMMARY, 8'h00, 16'h0000);
        wchk(`IDX_ERROR_SUMMARY, 8'h00, 16'h00FF, 1'b1);
        wchk(16'h7000, 8'h00, 16'h0000, 1'b1);
        $display("reset values done");
    endtask
    task automatic t_res();
        logic [15:0] st [4] = '{`RES_WHOLE, `RES_TENTH, `RES_HUNDREDTH, `RES_THOUSANDTH};
        for (int k = 0; k < 4; k++) begin
            wchk(`IDX_ANGLE_RESOLUTION, 8'h00, st[k], 1'b0);
            sample(-12345, 23456);
            `CHK("angle1", 16'(-12345 / int'(st[k])), angle1_out)
            `CHK("angle2", 16'(23456 / int'(st[k])), angle2_out)
        end
        wchk(`IDX_ANGLE_RESOLUTION, 8'h00, 16'h0005, 1'b1);
        rchk(`IDX_AXIS1_MEASURED, 8'h00, 16'hCFC7);
        $display("resolution done");
    endtask
    task automatic t_offset();
        wchk(`IDX_AXIS1_OFFSET, 8'h00, 16'd100, 1'b0);
        sample(5000, -7000);
        `CHK("angle1", 16'd5100, angle1_out)
        wchk(`IDX_AXIS1_OFFSET, 8'h00, 16'h0000, 1'b0);
        wchk(`IDX_AXIS1_PRESET, 8'h00, 16'd2000, 1'b0);
        rchk(`IDX_AXIS1_OFFSET, 8'h00, 16'(2000 - 5000));
        wchk(`IDX_AXIS2_PRESET, 8'h00, 16'h0000, 1'b0);
        rchk(`IDX_AXIS2_OFFSET, 8'h00, 16'd7000);
        sample(5000, -7000);
        `CHK("angle1", 16'd2000, angle1_out)
        `CHK("angle2", 16'd0, angle2_out)
        wchk(`IDX_AXIS1_INVERT, 8'h00, 16'(`INVERT_ON), 1'b0);
        sample(5000, -7000);
        `CHK("angle1", 16'(-2000), angle1_out)
        wchk(`IDX_AXIS1_INVERT, 8'h00, 16'h0000, 1'b0);
        wchk(`IDX_AXIS1_OFFSET, 8'h00, 16'h0000, 1'b0);
        $display("offset and preset done");
    endtask
    task automatic t_single();
        @(negedge mclk) single_axis = 1'b1;
        wchk(`IDX_AXIS2_PRESET, 8'h00, 16'd5, 1'b1);
        wchk(`IDX_ANGLE_RESOLUTION, 8'h00, `RES_WHOLE, 1'b0);
        sample(35000, 0);
        `CHK("single", 16'd35, angle1_out)
        `CHK("axis2 off", 16'd0, angle2_out)
        wchk(`IDX_AXIS1_INVERT, 8'h00, 16'(`INVERT_ON), 1'b0);
        sample(35000, 0);
        `CHK("circle", 16'd325, angle1_out)
        wchk(`IDX_SINGLE_FORMAT, 8'h00, 16'h0001, 1'b0);
        sample(35000, 0);
        `CHK("signed", 16'(-35), angle1_out)
        wchk(`IDX_AXIS1_INVERT, 8'h00, 16'h0000, 1'b0);
        wchk(`IDX_SINGLE_FORMAT, 8'h00, 16'h0000, 1'b0);
        sample(0, 0);  // park the angle, or thousandths would flag a range error later
        wchk(`IDX_ANGLE_RESOLUTION, 8'h00, `RES_THOUSANDTH, 1'b0);
        @(negedge mclk) single_axis = 1'b0;
        $display("single axis done");
    endtask
    task automatic t_temp();
        logic       sn, rm;
        logic [7:0] er;
        wchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_LOWER, 16'h00C8, 1'b1);
        wchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_LOWER, 16'h00C9, 1'b0);
        wchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_UPPER, 16'h0079, 1'b1);
        wchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_UPPER, 16'h0078, 1'b0);
        wchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_ENABLE, 16'h0002, 1'b1);
        wchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_ENABLE, 16'(`TEMP_ENABLE_ON), 1'b0);
        @(negedge mclk) temp_reading = 8'sd121;
        wait_send(sn, er, rm);
        `CHK("temp event", 1'b1, sn)
        `CHK("temp bits", 8'h09, er)
        rchk(`IDX_INT_TEMP, 8'h00, 16'h0079);
        `CHK("temp out", 8'sd121, temp_out)
        @(negedge mclk) temp_reading = 8'sd20;
        wait_send(sn, er, rm);
        `CHK("recovery", 1'b1, rm)
        wchk(`IDX_TEMP_SUPERVISION, `SUB_TEMP_ENABLE, 16'(`TEMP_ENABLE_OFF), 1'b0);
        @(negedge mclk) temp_reading = -8'sd56;
        wait_send(sn, er, rm);
        `CHK("disabled", 1'b0, sn)
        @(negedge mclk) temp_reading = 8'sd20;
        $display("temperature done");
    endtask
    task automatic t_faults();
        logic [7:0] ex [4] = '{8'h11, 8'h21, 8'h81, 8'h81};
        for (int b = 0; b < 4; b++) begin
            @(negedge mclk) faults = 4'h1 << b;
            repeat (3) @(negedge mclk);
            rchk(`IDX_ERROR_SUMMARY, 8'h00, {8'h00, ex[b]});
            @(negedge mclk) faults = 4'h0;
        end
        sample(31000, 0);
        rchk(`IDX_ERROR_SUMMARY, 8'h00, 16'h0021);
        $display("error register done");
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_res();
        t_offset();
        t_single();
        t_temp();
        t_faults();
        test_done();
    end
endmodule // tilt_angle_postproc_and_error_flags_bench
`default_nettype wire
